// ==== src/rrsb_regs.svh ====
// reset values and field constants for the rotate-right / subtract-borrow alu
`ifndef RRSB_REGS_SVH
`define RRSB_REGS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define RRSB_DATA_W      8
`define RRSB_MSB         7
`define RRSB_LSB         0
`define RRSB_NIB_MSB     3

// ****************************************************************
// reset values and the zero-result constant
// ****************************************************************
`define RRSB_WORK_RST    8'h00
`define RRSB_MEM_RST     8'h00
`define RRSB_ZERO_BYTE   8'h00
`define RRSB_FLAGS_RST   6'h00

`endif

// ==== src/rrsb_pkg.sv ====
// types shared by the rotate-right / subtract-borrow alu
package rrsb_pkg;

   // ****************************************************************
   // operation select from the instruction decoder
   // ****************************************************************
   typedef enum logic [2:0] {
      op_rotate_right_in_place,
      op_rotate_right_to_working,
      op_rotate_right_thru_borrow_bit_in_place,
      op_rotate_right_thru_borrow_bit_to_working,
      op_subtract_borrow_to_working,
      op_subtract_borrow_to_memory
   } rrsb_op_e;

   // ****************************************************************
   // status flag register, msb first
   // ****************************************************************
   typedef struct packed {
      logic signed_range_error_bit;
      logic zero_bit;
      logic nibble_borrow_bit;
      logic carry_bit;
      logic signed_compare_bit;
      logic chained_null_bit;
   } rrsb_flags_s;

   // ****************************************************************
   // one request: operation plus the addressed memory byte
   // ****************************************************************
   typedef struct packed {
      rrsb_op_e   op;
      logic [7:0] mem_byte;
   } rrsb_req_s;

endpackage : rrsb_pkg

// ==== src/rrsb_alu.sv ====
// rotate-right and subtract-with-borrow execute slice of an 8-bit core
`timescale 1ns/100ps
`default_nettype none
`include "rrsb_regs.svh"

module rrsb_alu (
   // clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_rst_b,
   // request from the instruction decoder
   input  wire logic               i_req_valid,
   input  wire rrsb_pkg::rrsb_req_s i_req,
   // direct loads of the working register and flags by the core
   input  wire logic               i_work_load,
   input  wire logic [7:0]         i_work_data,
   input  wire logic               i_flags_load,
   input  wire rrsb_pkg::rrsb_flags_s i_flags_data,
   // memory write-back
   output logic                    o_mem_wr,
   output logic [7:0]              o_mem_data,
   // architectural state
   output logic [7:0]              o_working,
   output rrsb_pkg::rrsb_flags_s   o_flags
);
   import rrsb_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0]  work_q,  work_d;
   rrsb_flags_s flags_q, flags_d;
   logic        mem_wr_q, mem_wr_d;
   logic [7:0]  mem_q,   mem_d;

   // ****************************************************************
   // datapath
   // ****************************************************************
   logic [7:0] rot_plain;
   logic [7:0] rot_ring;
   logic [8:0] diff9;
   logic [4:0] diff_lo;
   logic [7:0] diff;
   logic       sub_carry;
   logic       sub_ov;
   logic       sub_zero;

   // shift toward bit 0; bit 0 enters bit 7, or the carry bit does in the ring form
   assign rot_plain = {i_req.mem_byte[`RRSB_LSB],
                       i_req.mem_byte[`RRSB_MSB:1]};
   assign rot_ring  = {flags_q.carry_bit,
                       i_req.mem_byte[`RRSB_MSB:1]};

   // nine-bit difference; bit 8 is the borrow out of bit 7
   assign diff9   = {1'b0, work_q} - {1'b0, i_req.mem_byte}
                    - {8'h00, ~flags_q.carry_bit};
   assign diff    = diff9[7:0];
   // low nibble alone, to see the borrow out of bit 3
   assign diff_lo = {1'b0, work_q[`RRSB_NIB_MSB:0]}
                    - {1'b0, i_req.mem_byte[`RRSB_NIB_MSB:0]}
                    - {4'h0, ~flags_q.carry_bit};
   assign sub_carry = ~diff9[8];
   assign sub_zero  = (diff == `RRSB_ZERO_BYTE);
   // overflow: operands of unlike sign and result sign left the minuend
   assign sub_ov    = (work_q[`RRSB_MSB] ^ i_req.mem_byte[`RRSB_MSB]) &
                      (work_q[`RRSB_MSB] ^ diff[`RRSB_MSB]);

   // exact signed difference in ten bits, apart from the flag logic, so
   // the signed compare check does not just repeat the sign/overflow rule
   logic [9:0] sc_ref;
   assign sc_ref = {{2{work_q[`RRSB_MSB]}}, work_q}
                   - {{2{i_req.mem_byte[`RRSB_MSB]}}, i_req.mem_byte}
                   - {9'h000, ~flags_q.carry_bit};

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   // an executing operation takes priority over a core load that lands
   // in the same cycle, so a result is never overwritten silently
   always_comb begin
      work_d   = work_q;
      flags_d  = flags_q;
      mem_wr_d = 1'b0;
      mem_d    = mem_q;
      if (i_work_load) begin
         work_d = i_work_data;
      end
      if (i_flags_load) begin
         flags_d = i_flags_data;
      end
      if (i_req_valid) begin
         case (i_req.op)
            op_rotate_right_in_place: begin
               mem_wr_d = 1'b1;
               mem_d    = rot_plain;
            end
            op_rotate_right_to_working: begin
               work_d = rot_plain;
            end
            op_rotate_right_thru_borrow_bit_in_place: begin
               mem_wr_d          = 1'b1;
               mem_d             = rot_ring;
               flags_d.carry_bit = i_req.mem_byte[`RRSB_LSB];
            end
            op_rotate_right_thru_borrow_bit_to_working: begin
               work_d            = rot_ring;
               flags_d.carry_bit = i_req.mem_byte[`RRSB_LSB];
            end
            op_subtract_borrow_to_working,
            op_subtract_borrow_to_memory: begin
               if (i_req.op == op_subtract_borrow_to_memory) begin
                  mem_wr_d = 1'b1;
                  mem_d    = diff;
               end else begin
                  work_d = diff;
               end
               // all six flags follow the subtraction
               flags_d.signed_range_error_bit = sub_ov;
               flags_d.zero_bit               = sub_zero;
               flags_d.nibble_borrow_bit      = ~diff_lo[4];
               flags_d.carry_bit              = sub_carry;
               // signed minuend >= subtrahend when sign and overflow agree
               flags_d.signed_compare_bit     = ~(diff[`RRSB_MSB] ^ sub_ov);
               // zero across a multi-byte chain: this byte and the last
               flags_d.chained_null_bit       = sub_zero &
                                                flags_q.zero_bit;
            end
            default: begin
               mem_wr_d = 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         work_q   <= `RRSB_WORK_RST;
         flags_q  <= `RRSB_FLAGS_RST;
         mem_wr_q <= 1'b0;
         mem_q    <= `RRSB_MEM_RST;
      end else begin
         work_q   <= work_d;
         flags_q  <= flags_d;
         mem_wr_q <= mem_wr_d;
         mem_q    <= mem_d;
      end
   end

   // outputs straight from flip-flops
   assign o_mem_wr   = mem_wr_q;
   assign o_mem_data = mem_q;
   assign o_working  = work_q;
   assign o_flags    = flags_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   sequence seq_issue(rrsb_op_e op);
      i_req_valid && i_req.op == op;
   endsequence

   sequence seq_sub_issue;
      i_req_valid && (i_req.op == op_subtract_borrow_to_working ||
                      i_req.op == op_subtract_borrow_to_memory);
   endsequence

   chk_rot_in_place: assert property (
      seq_issue(op_rotate_right_in_place) |=> o_mem_wr &&
      o_mem_data == {$past(i_req.mem_byte[0]),
                     $past(i_req.mem_byte[7:1])} &&
      o_flags == $past(o_flags))
      else $error("in-place rotate result or flags wrong");

   chk_rot_to_work: assert property (
      seq_issue(op_rotate_right_to_working) |=> !o_mem_wr &&
      o_working == {$past(i_req.mem_byte[0]),
                    $past(i_req.mem_byte[7:1])} &&
      $stable(o_flags))
      else $error("rotate to working register wrong");

   chk_ring_in_place: assert property (
      seq_issue(op_rotate_right_thru_borrow_bit_in_place) |=> o_mem_wr &&
      o_mem_data == {$past(o_flags.carry_bit),
                     $past(i_req.mem_byte[7:1])} &&
      o_flags.carry_bit == $past(i_req.mem_byte[0]) &&
      o_flags.zero_bit == $past(o_flags.zero_bit))
      else $error("ring rotate in place wrong");

   chk_ring_to_work: assert property (
      seq_issue(op_rotate_right_thru_borrow_bit_to_working) |=>
      !o_mem_wr && o_working[7] == $past(o_flags.carry_bit) &&
      o_flags.carry_bit == $past(i_req.mem_byte[0]) &&
      $stable(o_flags.signed_range_error_bit))
      else $error("ring rotate to working register wrong");

   chk_sub_working: assert property (
      seq_issue(op_subtract_borrow_to_working) |=> !o_mem_wr &&
      o_working == 8'($past(o_working) - $past(i_req.mem_byte) -
                      {7'h00, !$past(o_flags.carry_bit)}))
      else $error("subtract to working register wrong");

   chk_sub_memory: assert property (
      seq_issue(op_subtract_borrow_to_memory) |=> o_mem_wr &&
      $stable(o_working) &&
      o_mem_data == 8'($past(o_working) - $past(i_req.mem_byte) -
                       {7'h00, !$past(o_flags.carry_bit)}))
      else $error("subtract to memory wrong");

   chk_sub_carry: assert property (
      seq_sub_issue |=> o_flags.carry_bit ==
      ({1'b0, $past(o_working)} >= ({1'b0, $past(i_req.mem_byte)} +
                                    {8'h00, !$past(o_flags.carry_bit)})))
      else $error("carry is not the inverted borrow");

   chk_sub_zero: assert property (
      seq_sub_issue ##1 o_mem_wr |-> o_flags.zero_bit ==
      (o_mem_data == `RRSB_ZERO_BYTE))
      else $error("zero flag disagrees with memory result");

   chk_sub_sign: assert property (
      seq_sub_issue |=>
      o_flags.signed_compare_bit == !$past(sc_ref[9]))
      else $error("signed compare flag inconsistent");

   chk_idle_quiet: assert property (
      !i_req_valid |=> !o_mem_wr)
      else $error("memory write without an operation");

endmodule : rrsb_alu
`default_nettype wire

// ==== test/rrsb_mem_model.sv ====
// data memory model holding the byte addressed by the decoder
`timescale 1ns/100ps
`default_nettype none

module rrsb_mem_model (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   // preload from the bench, write-back from the alu
   input  wire logic       i_pre,
   input  wire logic [7:0] i_pre_data,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wr_data,
   // addressed byte
   output logic [7:0]      o_byte
);
   // ****
   // storage
   // ****
   // write-back wins so an in-place result is never lost to a preload
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) o_byte <= 8'h00;
      else if (i_wr) o_byte <= i_wr_data;
      else if (i_pre) o_byte <= i_pre_data;
   end
endmodule : rrsb_mem_model

`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the rotate-right / subtract-borrow alu
`timescale 1ns/100ps
`default_nettype none

module tb;
   import rrsb_pkg::*;
   // one row: stimulus beside the expected result byte
   typedef struct {
      rrsb_op_e   op;
      logic [7:0] w, m, res;
      logic       c;
   } rrsb_row_s;
   logic        i_clk = 0, i_rst_b = 0, req_valid = 0;
   logic        work_load = 0, flags_load = 0, pre = 0, wr;
   logic [7:0]  work_data = 0, pre_data = 0, mem_byte;
   logic [7:0]  mem_data, working;
   logic        mem_wr;
   rrsb_op_e    op = op_rotate_right_in_place;
   rrsb_flags_s flags_data = '0, flags, ef, f;
   rrsb_req_s   req;
   int          n_errors = 0, checks_done = 0;
   rrsb_row_s   rows [10];

   // ****
   // clock, design and partner
   // ****
   always #10 i_clk = ~i_clk;
   assign req = {op, mem_byte};

   rrsb_alu i_rrsb_alu (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_req_valid(req_valid), .i_req(req),
      .i_work_load(work_load), .i_work_data(work_data),
      .i_flags_load(flags_load), .i_flags_data(flags_data),
      .o_mem_wr(mem_wr), .o_mem_data(mem_data),
      .o_working(working), .o_flags(flags));

   rrsb_mem_model i_rrsb_mem_model (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_pre(pre), .i_pre_data(pre_data), .i_wr(mem_wr),
      .i_wr_data(mem_data), .o_byte(mem_byte));

   // ****
   // helpers
   // ****
   task automatic chk(input string nm, input logic [7:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic report_and_stop();
      if (n_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   // flags model kept apart from the design on purpose
   function automatic rrsb_flags_s exp_flags(rrsb_op_e o,
      logic [7:0] w, m, rrsb_flags_s fi);
      logic [8:0] d;
      logic [4:0] n;
      logic       ov;
      exp_flags = fi;
      d = {1'b0, w} - {1'b0, m} - {8'h00, ~fi.carry_bit};
      n = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~fi.carry_bit};
      ov = (w[7] ^ m[7]) & (d[7] ^ w[7]);
      if (o == op_rotate_right_thru_borrow_bit_in_place ||
          o == op_rotate_right_thru_borrow_bit_to_working)
         exp_flags.carry_bit = m[0];
      if (o == op_subtract_borrow_to_working ||
          o == op_subtract_borrow_to_memory)
         exp_flags = {ov, d[7:0] == 8'h00, ~n[4], ~d[8], ~(d[7] ^ ov),
                      (d[7:0] == 8'h00) & fi.zero_bit};
   endfunction : exp_flags

   // load state and memory, then one request; loads never meet the op
   task automatic run(input rrsb_op_e o, input logic [7:0] w, m,
                      input rrsb_flags_s fi);
      @(posedge i_clk);
      work_load <= 1'b1;
      work_data <= w;
      flags_load <= 1'b1;
      flags_data <= fi;
      pre <= 1'b1;
      pre_data <= m;
      @(posedge i_clk);
      work_load <= 1'b0;
      flags_load <= 1'b0;
      pre <= 1'b0;
      req_valid <= 1'b1;
      op <= o;
      @(posedge i_clk);
      req_valid <= 1'b0;
      #1;
   endtask : run

   // ****
   // main sequence
   // ****
   initial begin
      rows = '{
         '{op_rotate_right_in_place, 8'h5A, 8'h01, 8'h80, 1'b0},
         '{op_rotate_right_to_working, 8'h5A, 8'h02, 8'h01, 1'b1},
         '{op_rotate_right_thru_borrow_bit_in_place,
           8'h00, 8'h01, 8'h80, 1'b1},
         '{op_rotate_right_thru_borrow_bit_in_place,
           8'h00, 8'hFE, 8'h7F, 1'b0},
         '{op_rotate_right_thru_borrow_bit_to_working,
           8'h11, 8'h81, 8'h40, 1'b0},
         '{op_subtract_borrow_to_working, 8'h05, 8'h03, 8'h02, 1'b1},
         '{op_subtract_borrow_to_working, 8'h03, 8'h05, 8'hFE, 1'b1},
         '{op_subtract_borrow_to_working, 8'h80, 8'h01, 8'h7F, 1'b1},
         '{op_subtract_borrow_to_memory, 8'h10, 8'h0F, 8'h00, 1'b0},
         '{op_subtract_borrow_to_memory, 8'h00, 8'h00, 8'hFF, 1'b0}};
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;
      foreach (rows[i]) begin
         f = {1'b1, 1'b1, 1'b0, rows[i].c, 1'b1, 1'b0};
         run(rows[i].op, rows[i].w, rows[i].m, f);
         ef = exp_flags(rows[i].op, rows[i].w, rows[i].m, f);
         wr = rows[i].op inside {op_rotate_right_in_place,
            op_rotate_right_thru_borrow_bit_in_place,
            op_subtract_borrow_to_memory};
         chk("working", (wr || rows[i].op == op_rotate_right_in_place ||
             rows[i].op == op_subtract_borrow_to_memory) ? rows[i].w :
             rows[i].res, working);
         chk("flags", {2'b00, ef}, {2'b00, flags});
         chk("mem_wr", {7'h00, wr}, {7'h00, mem_wr});
         if (wr) chk("mem_data", rows[i].res, mem_data);
         @(posedge i_clk);
         #1;
         chk("mem_wr_end", 8'h00, {7'h00, mem_wr});
         chk("memory", wr ? rows[i].res : rows[i].m, mem_byte);
      end
      // back-to-back ring rotates; the op beats a working load
      @(posedge i_clk);
      flags_load <= 1'b1;
      flags_data <= '0;
      pre <= 1'b1;
      pre_data <= 8'h01;
      @(posedge i_clk);
      flags_load <= 1'b0;
      pre <= 1'b0;
      req_valid <= 1'b1;
      op <= op_rotate_right_thru_borrow_bit_to_working;
      @(posedge i_clk);
      work_load <= 1'b1;
      work_data <= 8'h33;
      @(posedge i_clk);
      req_valid <= 1'b0;
      work_load <= 1'b0;
      #1;
      chk("ring_working", 8'h80, working);
      chk("ring_carry", 8'h01, {7'h00, flags.carry_bit});
      // reset in mid-run clears state at once
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      #1;
      chk("rst_working", 8'h00, working);
      chk("rst_flags", 8'h00, {2'b00, flags});
      chk("rst_mem_data", 8'h00, mem_data);
      chk("rst_mem_wr", 8'h00, {7'h00, mem_wr});
      @(posedge i_clk);
      i_rst_b <= 1'b1;
      // first request sits on the very first edge after release
      req_valid <= 1'b1;
      op <= op_subtract_borrow_to_working;
      @(posedge i_clk);
      req_valid <= 1'b0;
      #1;
      chk("post_rst_working", 8'hFF, working);
      ef = exp_flags(op_subtract_borrow_to_working, 8'h00, 8'h00, '0);
      chk("post_rst_flags", {2'b00, ef}, {2'b00, flags});
      report_and_stop();
   end

   // watchdog so a hang still reaches the verdict
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end
endmodule : tb

`default_nettype wire
